// file: esq_scan_sequencer.sv
// Scan sequencer routing relay channels to an external meter, with AHB-Lite registers
//
// Functional notes
// RL1 - External scan starts only while the internal meter is switched off.
// RL2 - With the internal meter off, no readings go to internal memory.
// RL3 - Two-wire scan uses two handshake lines, four-wire scan uses four.
// RL4 - After a relay closes and settles, a settled pulse goes to the meter.
// RL5 - The external meter signals when done and ready for the next channel.
// RL6 - The advance request on the trigger input moves the scan to the next channel.
// RL7 - Four-wire scanning closes channel n together with channel n+10.
// RL8 - Switch mode opens or closes each multiplexer channel individually, outside any scan.
// RL9 - Switch mode exists only on multiplexer-type modules.
// RL10 - Remove-all clears scan inclusion of every channel, making them switchable.
// RL11 - A channel without measurement function may set switch and bank join.
// RL12 - Assigning a function re-includes the channel and locks switch and bank join.
// RL13 - Enabling bank join on one channel enables it on all channels; the code enables it only on channels without a measurement function.
// RL14 - Hold relay until advance, open before next close, stop after last channel.
// RL15 - One fixed-width settled pulse per closure, never repeated while waiting.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module esq_scan_sequencer (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic      [31:0]             hrdata,
  input  wire logic                    next_channel_request,
  input  wire logic                    sense_next_request,
  input  wire logic                    module_is_mux,
  output logic                         relay_settled_pulse,
  output logic                         sense_settled_pulse,
  output logic      [esq_pkg::NCH-1:0] relay_close,
  output logic      [esq_pkg::NCH-1:0] bank_join_enable,
  output logic                         meter_store_en,
  output logic                         scan_busy
);
  localparam int NCH = esq_pkg::NCH;
  localparam int CHW = esq_pkg::CHW;

  esq_pkg::esq_main_type s;
  esq_pkg::esq_main_type d;

  logic [esq_pkg::NSYNC-1:0] pins_sync;
  logic [esq_pkg::FUNCW-1:0] mem_rdata;
  logic                      mem_wr;
  logic [CHW-1:0]            mem_waddr;
  logic [esq_pkg::FUNCW-1:0] mem_wdata;

  logic                      accept;
  logic                      wr_ctrl;
  logic                      wr_incl;
  logic                      wr_sw;
  logic                      wr_join;
  logic                      wr_func;
  logic                      is_mux;
  logic [NCH-1:0]            elig;
  logic [NCH-1:0]            scan_mask;
  logic [CHW:0]              nxt;
  logic                      adv_rise;
  logic                      sadv_rise;
  logic                      adv_ready;
  logic [CHW-1:0]            fch;
  logic [esq_pkg::FUNCW-1:0] fcode;
  logic [NCH-1:0]            fbit;
  logic [NCH-1:0]            start_mask;
  logic                      scan_on;

  // Write data phase that hits one register offset
  function automatic logic wr_hit(input logic                   pend,
                                  input logic [esq_pkg::AW-1:0] addr,
                                  input logic [esq_pkg::AW-1:0] ofs);
    return pend && (addr == ofs);
  endfunction

  // States in which the scanned channel (and its pair) stays closed
  function automatic logic holds_relay(input esq_pkg::esq_fsm_type f);
    return (f == esq_pkg::ST_SETTLE) || (f == esq_pkg::ST_NOTIFY) || (f == esq_pkg::ST_WAIT);
  endfunction

  esq_sync u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({module_is_mux, sense_next_request, next_channel_request}),
    .dout  (pins_sync)
  );

  // Function code of the selected channel reads back one cycle after selection
  esq_func_mem u_mem (
    .clock (clock),
    .rstn  (rstn),
    .wr_en (mem_wr),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (s.fsel),
    .rdata (mem_rdata)
  );

  // Word transfers only; other sizes pass as no-ops with OKAY
  assign accept    = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign wr_ctrl   = wr_hit(s.wr_pend, s.addr, esq_pkg::OFS_CTRL);
  assign wr_incl   = wr_hit(s.wr_pend, s.addr, esq_pkg::OFS_INCL);
  assign wr_sw     = wr_hit(s.wr_pend, s.addr, esq_pkg::OFS_SW);
  assign wr_join   = wr_hit(s.wr_pend, s.addr, esq_pkg::OFS_JOIN);
  assign wr_func   = wr_hit(s.wr_pend, s.addr, esq_pkg::OFS_FUNC);
  assign scan_on   = (s.fsm != esq_pkg::ST_IDLE);
  // Module type pin lags by two edges, so a module swap applies a little late
  assign is_mux    = pins_sync[esq_pkg::SY_MUX];

  // Only function-free channels on a multiplexer module may switch
  assign elig      = ~s.func_set & {NCH{is_mux}}; // RL9 RL11
  assign scan_mask = s.four_wire ? (s.incl & esq_pkg::PAIR_MASK) : s.incl; // RL7
  // A start write may set the pairing too, so its first channel follows the new mode
  assign start_mask = hwdata[esq_pkg::CTRL_4W] ? (s.incl & esq_pkg::PAIR_MASK) : s.incl; // RL7

  assign fch       = hwdata[esq_pkg::FUNC_CH +: CHW];
  assign fcode     = hwdata[esq_pkg::FUNC_CODE +: esq_pkg::FUNCW];
  assign fbit      = (fch < CHW'(NCH)) ? (NCH'(1) << fch) : '0;

  assign mem_wr    = wr_func;
  assign mem_waddr = fch;
  assign mem_wdata = fcode;

  // Rising edges of the synchronised request lines
  assign adv_rise  = pins_sync[esq_pkg::SY_ADV] && !s.adv_prev;
  assign sadv_rise = pins_sync[esq_pkg::SY_SADV] && !s.sadv_prev;
  // Four-wire needs both meter requests before the scan moves on
  assign adv_ready = (s.adv_got || adv_rise) &&
                     (!s.four_wire || s.sadv_got || sadv_rise); // RL3 RL5 RL6

  always_comb begin
    d           = s;
    d.adv_prev  = pins_sync[esq_pkg::SY_ADV];
    d.sadv_prev = pins_sync[esq_pkg::SY_SADV];
    // Pulses are re-armed each cycle by their state, so an abort cuts them short
    d.pulse     = 1'b0;
    d.spulse    = 1'b0;
    nxt         = '0;

    // Bus address and data phases
    d.wr_pend = accept && hwrite;
    d.rd_pend = accept && !hwrite;
    if (accept) begin
      d.addr = haddr[esq_pkg::AW-1:0];
    end
    if (s.rd_pend) begin
      case (s.addr)
        esq_pkg::OFS_CTRL: d.rdata = 32'(
          {s.four_wire, s.meter_on} << esq_pkg::CTRL_METER);
        esq_pkg::OFS_STAT: d.rdata =
          (32'(scan_on) << esq_pkg::STAT_BUSY) |
          (32'(s.cur) << esq_pkg::STAT_CUR) |
          (32'(s.meter_on) << esq_pkg::STAT_METER) |
          (32'(is_mux) << esq_pkg::STAT_MUX);
        esq_pkg::OFS_INCL: d.rdata = 32'(s.incl);
        esq_pkg::OFS_SW:   d.rdata = 32'(s.swc);
        esq_pkg::OFS_JOIN: d.rdata = 32'(s.join_en);
        esq_pkg::OFS_FUNC: d.rdata =
          (32'(s.fsel) << esq_pkg::FUNC_CH) | (32'(mem_rdata) << esq_pkg::FUNC_CODE);
        default:           d.rdata = 32'h0000_0000;
      endcase
    end

    // Configuration writes
    if (wr_ctrl) begin
      d.meter_on = hwdata[esq_pkg::CTRL_METER];
      // Pairing is frozen while a scan runs
      if (s.fsm == esq_pkg::ST_IDLE) begin
        d.four_wire = hwdata[esq_pkg::CTRL_4W];
      end
      if (hwdata[esq_pkg::CTRL_RMALL]) begin
        d.incl     = '0; // RL10
        d.func_set = '0; // RL10
      end
    end
    if (wr_incl) begin
      d.incl = hwdata[NCH-1:0];
    end
    if (wr_sw) begin
      d.swc = (hwdata[NCH-1:0] & elig) | (s.swc & ~elig); // RL8 RL11
    end
    if (wr_join) begin
      if (|(hwdata[NCH-1:0] & elig)) begin
        d.join_en = '1; // RL13
      end else begin
        d.join_en = s.join_en & ~elig;
      end
    end
    if (wr_func) begin
      d.fsel = fch;
      if (fcode != esq_pkg::FUNC_NONE) begin
        d.func_set = s.func_set | fbit;
        d.incl     = s.incl | fbit; // RL12
        d.swc      = s.swc & ~fbit; // RL12
      end else begin
        d.func_set = s.func_set & ~fbit;
      end
    end

    // Scan sequencing
    case (s.fsm)
      esq_pkg::ST_IDLE: begin
        // Stale request edges from a finished scan are dropped
        d.adv_got  = 1'b0;
        d.sadv_got = 1'b0;
        nxt = esq_pkg::esq_next(start_mask, '0);
        if (wr_ctrl && hwdata[esq_pkg::CTRL_START] && !hwdata[esq_pkg::CTRL_METER] &&
            !s.meter_on && nxt[CHW]) begin // RL1
          d.cur = nxt[CHW-1:0];
          d.fsm = esq_pkg::ST_BREAK;
        end
      end
      esq_pkg::ST_BREAK: begin
        // One open cycle so two channels never share the common terminal
        d.cnt = esq_pkg::SETTLE_CYC;
        d.fsm = esq_pkg::ST_SETTLE; // RL14
      end
      esq_pkg::ST_SETTLE: begin
        d.cnt = s.cnt - 1'b1;
        if (s.cnt == esq_pkg::CNTW'(1)) begin
          d.cnt    = esq_pkg::PULSE_CYC;
          d.pulse  = 1'b1; // RL4
          d.spulse = s.four_wire; // RL3
          d.fsm    = esq_pkg::ST_NOTIFY;
        end
      end
      esq_pkg::ST_NOTIFY: begin
        d.cnt    = s.cnt - 1'b1;
        d.pulse  = 1'b1; // RL15
        d.spulse = s.four_wire;
        if (s.cnt == esq_pkg::CNTW'(1)) begin
          d.pulse    = 1'b0;
          d.spulse   = 1'b0;
          d.adv_got  = 1'b0;
          d.sadv_got = 1'b0;
          d.fsm      = esq_pkg::ST_WAIT;
        end
      end
      esq_pkg::ST_WAIT: begin
        // Edges are latched, so the two request lines may come in either order
        d.adv_got  = s.adv_got || adv_rise;
        d.sadv_got = s.sadv_got || sadv_rise;
        if (adv_ready) begin // RL6
          d.adv_got  = 1'b0;
          d.sadv_got = 1'b0;
          nxt = esq_pkg::esq_next(scan_mask, CHW'(s.cur + 1'b1));
          if (nxt[CHW] && (s.cur != CHW'(NCH - 1))) begin
            d.cur = nxt[CHW-1:0];
            d.fsm = esq_pkg::ST_BREAK; // RL14
          end else begin
            d.fsm = esq_pkg::ST_IDLE; // RL14
          end
        end
      end
      default: begin
        d.fsm = esq_pkg::ST_IDLE;
      end
    endcase

    // Turning the meter back on or abort ends any scan
    if ((wr_ctrl && (hwdata[esq_pkg::CTRL_ABORT] || hwdata[esq_pkg::CTRL_METER])) ||
        s.meter_on) begin // RL1
      d.fsm    = esq_pkg::ST_IDLE;
      d.pulse  = 1'b0;
      d.spulse = 1'b0;
    end

    // Relay drive: scanned channel (and its pair) plus switch-mode channels
    // Switch channels stay closed through a scan; keep them off the scanned bank
    d.relay = d.swc & ~d.incl & ~d.func_set; // RL8 RL10
    if (holds_relay(d.fsm)) begin // RL14
      d.relay[d.cur] = 1'b1;
      if (s.four_wire) begin
        d.relay[CHW'(d.cur + esq_pkg::PAIR_OFS)] = 1'b1; // RL7
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s          <= '0;
      s.fsm      <= esq_pkg::ST_IDLE;
      s.meter_on <= esq_pkg::METER_RST;
    end else begin
      s <= d;
    end
  end

  // Reads take one wait state so read data always come from a register
  assign hreadyout           = !s.rd_pend;
  assign hresp               = 1'b0;
  assign hrdata              = s.rdata;
  assign relay_settled_pulse = s.pulse; // RL4
  assign sense_settled_pulse = s.spulse; // RL3
  assign relay_close         = s.relay;
  assign bank_join_enable    = s.join_en & ~s.func_set; // RL12
  assign meter_store_en      = s.meter_on; // RL2
  assign scan_busy           = scan_on;
endmodule // esq_scan_sequencer

// file: esq_pkg.sv
// Package for the external meter scan sequencer: constants, types, helpers
package esq_pkg;

  localparam int NCH       = 20;
  localparam int CHW       = 5;
  localparam int FUNCW     = 4;
  localparam int AW        = 8;
  localparam int CNTW      = 12;
  localparam int NSYNC     = 3;

  localparam logic [CHW-1:0] PAIR_OFS = 5'h0_00a;
  localparam logic [NCH-1:0] PAIR_MASK = 20'h0_03ff;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h0_000;
  localparam logic [AW-1:0] OFS_STAT = 8'h0_004;
  localparam logic [AW-1:0] OFS_INCL = 8'h0_008;
  localparam logic [AW-1:0] OFS_SW   = 8'h0_00c;
  localparam logic [AW-1:0] OFS_JOIN = 8'h0_010;
  localparam logic [AW-1:0] OFS_FUNC = 8'h0_014;

  // Control register fields
  localparam int CTRL_METER = 0;
  localparam int CTRL_4W    = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_ABORT = 3;
  localparam int CTRL_RMALL = 4;
  localparam logic METER_RST = 1'b1;

  // Status and function register fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_CUR   = 8;
  localparam int STAT_METER = 16;
  localparam int STAT_MUX   = 17;
  localparam int FUNC_CH    = 0;
  localparam int FUNC_CODE  = 8;
  localparam logic [FUNCW-1:0] FUNC_NONE = 4'h0;

  // Sync input bit positions
  localparam int SY_ADV  = 0;
  localparam int SY_SADV = 1;
  localparam int SY_MUX  = 2;

  // Timing
  localparam int CLK_MHZ   = 125;
  localparam int SETTLE_NS = 2000;
  localparam int PULSE_NS  = 400;
  localparam logic [CNTW-1:0] SETTLE_CYC = CNTW'((SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNTW-1:0] PULSE_CYC  = CNTW'((PULSE_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_BREAK  = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_NOTIFY = 5'b01000,
    ST_WAIT   = 5'b10000
  } esq_fsm_type;

  typedef struct packed {
    esq_fsm_type       fsm;
    logic              meter_on;
    logic              four_wire;
    logic [NCH-1:0]    incl;
    logic [NCH-1:0]    swc;
    logic [NCH-1:0]    join_en;
    logic [NCH-1:0]    func_set;
    logic [NCH-1:0]    relay;
    logic [CHW-1:0]    cur;
    logic [CHW-1:0]    fsel;
    logic [CNTW-1:0]   cnt;
    logic              pulse;
    logic              spulse;
    logic              adv_prev;
    logic              sadv_prev;
    logic              adv_got;
    logic              sadv_got;
    logic              wr_pend;
    logic              rd_pend;
    logic [AW-1:0]     addr;
    logic [31:0]       rdata;
  } esq_main_type;

  typedef struct packed {
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] stab;
  } esq_sync_type;

  typedef struct packed {
    logic [NCH-1:0][FUNCW-1:0] word;
    logic [FUNCW-1:0]          rdata;
  } esq_mem_type;

  // Lowest set bit of mask at or above lo; top bit flags a hit
  function automatic logic [CHW:0] esq_next(input logic [NCH-1:0] mask, input logic [CHW-1:0] lo);
    logic [CHW:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (mask[i] && (CHW'(i) >= lo)) begin
        r = {1'b1, CHW'(i)};
      end
    end
    return r;
  endfunction

endpackage

// file: esq_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module esq_sync (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic [esq_pkg::NSYNC-1:0] din,
  output logic      [esq_pkg::NSYNC-1:0] dout
);
  esq_pkg::esq_sync_type s;
  esq_pkg::esq_sync_type d;

  always_comb begin
    d.meta = din;
    d.stab = s.meta;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign dout = s.stab;
endmodule // esq_sync

// file: esq_func_mem.sv
// Per-channel measurement function store with registered read
`timescale 1ns/1ps
module esq_func_mem (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      wr_en,
  input  wire logic [esq_pkg::CHW-1:0]   waddr,
  input  wire logic [esq_pkg::FUNCW-1:0] wdata,
  input  wire logic [esq_pkg::CHW-1:0]   raddr,
  output logic      [esq_pkg::FUNCW-1:0] rdata
);
  esq_pkg::esq_mem_type s;
  esq_pkg::esq_mem_type d;

  always_comb begin
    d = s;
    if (wr_en && (waddr < esq_pkg::CHW'(esq_pkg::NCH))) begin
      d.word[waddr] = wdata;
    end
    d.rdata = (raddr < esq_pkg::CHW'(esq_pkg::NCH)) ? s.word[raddr] : esq_pkg::FUNC_NONE;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign rdata = s.rdata;
endmodule // esq_func_mem

// file: esq_sva.sv
// Concurrent checks on the scan sequencer ports
`timescale 1ns/1ps
module esq_sva (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic                    next_channel_request,
  input wire logic                    relay_settled_pulse,
  input wire logic                    sense_settled_pulse,
  input wire logic [esq_pkg::NCH-1:0] relay_close,
  input wire logic                    meter_store_en,
  input wire logic                    scan_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  logic [esq_pkg::NCH-1:0] rc_q;
  logic [8:0]              stab_q;
  logic [6:0]              pw_q;
  logic [3:0]              req_q;

  // Saturating ages: relays unchanged, pulse high, since request edge
  always_ff @(posedge clock) begin
    rc_q   <= relay_close;
    stab_q <= (!rstn || relay_close != rc_q) ? 9'h000 : stab_q + 9'(stab_q != 9'h1ff);
    pw_q   <= (!rstn || !relay_settled_pulse) ? 7'h00 : pw_q + 7'(pw_q != 7'h7f);
    req_q  <= (!rstn || $rose(next_channel_request)) ? 4'h0 : req_q + 4'(req_q != 4'hf);
  end

  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  start_meter_off_a: assert property ($rose(scan_busy) |-> !meter_store_en)
    else $error("scan started with meter on");
  no_store_a: assert property (scan_busy |-> !meter_store_en)
    else $error("storage enabled during scan");
  sense_pair_a: assert property (sense_settled_pulse |-> relay_settled_pulse)
    else $error("sense pulse without relay pulse");
  settle_time_a: assert property ($rose(relay_settled_pulse) |-> stab_q == 9'h0f9 && relay_close != '0)
    else $error("pulse before relay settled");
  pulse_width_a: assert property ($fell(relay_settled_pulse) && scan_busy |-> pw_q == 7'h32)
    else $error("settled pulse width wrong");
  no_repeat_a: assert property (relay_settled_pulse |-> stab_q inside {[249:298]})
    else $error("settled pulse repeated");
  pair_close_a: assert property ($rose(sense_settled_pulse) |-> relay_close[19:10] == relay_close[9:0])
    else $error("four wire pair not closed");
  break_first_a: assert property (scan_busy && $past(scan_busy) && $changed(relay_close)
    |-> relay_close == '0 || $past(relay_close) == '0)
    else $error("relay switched without break");
  advance_req_a: assert property (scan_busy && $fell(|relay_close) |-> req_q <= 4'h5)
    else $error("advance without request");
  read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> rd_wait)
    else $error("read wait state wrong");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("error response");
endmodule // esq_sva

bind esq_scan_sequencer esq_sva u_sva (
  .clock(clock), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .next_channel_request(next_channel_request),
  .relay_settled_pulse(relay_settled_pulse), .sense_settled_pulse(sense_settled_pulse),
  .relay_close(relay_close), .meter_store_en(meter_store_en), .scan_busy(scan_busy)
);

// file: esq_meter_model.sv
// External meter model answering settled pulses with advance requests
`timescale 1ns/1ps
module esq_meter_model (
  input  wire logic       clock,
  input  wire logic       four_wire,
  input  wire logic       hold,
  input  wire logic [7:0] delay,
  input  wire logic       relay_settled_pulse,
  output logic            next_channel_request,
  output logic            sense_next_request,
  output int              seen
);
  initial begin
    next_channel_request = 1'b0;
    sense_next_request = 1'b0;
    seen = 0;
    forever begin
      // A real rise first, so the pulse clearing in reset is not counted
      @(posedge relay_settled_pulse);
      @(negedge relay_settled_pulse);
      seen++;
      // Measurement time, then ready for the next channel
      repeat (delay) @(posedge clock);
      while (hold) @(posedge clock);
      @(posedge clock);
      next_channel_request <= 1'b1;
      @(posedge clock);
      // Second line only on four-wire scans, deliberately late
      sense_next_request <= four_wire;
      repeat (4) @(posedge clock);
      next_channel_request <= 1'b0;
      sense_next_request <= 1'b0;
    end
  end
endmodule // esq_meter_model

// file: tb.sv
// Self-checking bench for the external meter scan sequencer
`timescale 1ns/1ps
module tb;
  logic                    clock = 1'b0;
  logic                    rstn = 1'b0;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0000_0000;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [31:0]             hwdata = 32'h0000_0000;
  logic                    mux = 1'b1;
  logic                    hold = 1'b0;
  logic                    four_w = 1'b0;
  logic [7:0]              dly = 8'h00;
  logic                    hreadyout, hresp, next_req, sense_req, pulse, spulse, store_en, busy;
  logic [31:0]             hrdata, rd;
  logic [esq_pkg::NCH-1:0] relay, join_en, sw;
  int                      seed = 21058, mismatches = 0, samples_checked = 0, cyc = 0, seen;
  int                      q[$];
  logic [7:0]              ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40};
  logic [31:0]             rv[6] = '{32'h0000_0001, 32'h0003_0000, 0, 0, 0, 0};

  esq_scan_sequencer dut (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .next_channel_request(next_req), .sense_next_request(sense_req),
    .module_is_mux(mux), .relay_settled_pulse(pulse), .sense_settled_pulse(spulse),
    .relay_close(relay), .bank_join_enable(join_en), .meter_store_en(store_en), .scan_busy(busy)
  );

  esq_meter_model meter (
    .clock(clock), .four_wire(four_w), .hold(hold), .delay(dly), .relay_settled_pulse(pulse),
    .next_channel_request(next_req), .sense_next_request(sense_req), .seen(seen)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Hold each phase until hready is seen high at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clock); rd = hrdata; end while (hreadyout !== 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  task automatic run_scan(input logic fw, input logic [19:0] inc);
    logic [19:0] exp;
    int          base;
    q.delete();
    for (int i = 0; i < 20; i++) if (inc[i] && (!fw || i < 10)) q.push_back(i);
    base = seen;
    hold <= 1'b1;
    four_w <= fw;
    dly <= 8'($random(seed));
    bus(1'b1, esq_pkg::OFS_INCL, 32'(inc));
    bus(1'b1, esq_pkg::OFS_CTRL, {30'h0, fw, 1'b0});
    bus(1'b1, esq_pkg::OFS_CTRL, {29'h0, 1'b1, fw, 1'b0});
    foreach (q[k]) begin
      exp = 20'h1 << q[k];
      if (fw) exp = exp | (exp << 10);
      do @(negedge clock); while (relay === '0);
      chk(32'(relay), 32'(exp), "closed relays");
      if (k == 0) begin
        repeat (500) @(negedge clock);
        chk(32'(relay), 32'(exp), "relay held");
        @(posedge clock);
        hold <= 1'b0;
      end
      do @(negedge clock); while (relay !== '0);
    end
    do @(negedge clock); while (busy !== 1'b0);
    chk(32'(seen - base), 32'(q.size()), "pulse count");
    chk({31'h0, store_en}, 32'h0, "store enable");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, store_en}, 32'h1, "store enable");
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i], "reset value");
    // Start refused while the meter is on
    bus(1'b1, esq_pkg::OFS_INCL, 32'h0000_0001);
    bus(1'b1, esq_pkg::OFS_CTRL, 32'h0000_0005);
    repeat (5) @(negedge clock);
    chk({31'h0, busy}, 32'h0, "busy with meter on");
    bus(1'b1, esq_pkg::OFS_CTRL, 32'h0000_0000);
    run_scan(1'b0, 20'($random(seed)) | 20'h1);
    run_scan(1'b1, 20'($random(seed)) | 20'h8);
    // Abort in mid-settle ends the scan and opens the relay
    bus(1'b1, esq_pkg::OFS_INCL, 32'h0000_0004);
    bus(1'b1, esq_pkg::OFS_CTRL, 32'h0000_0004);
    rd_chk(esq_pkg::OFS_STAT, 32'h0002_0201, "status");
    chk(32'(relay), 32'h0000_0004, "relay before abort");
    bus(1'b1, esq_pkg::OFS_CTRL, 32'h0000_0008);
    @(negedge clock);
    chk({busy, 11'h000, relay}, 32'h0000_0000, "abort");
    bus(1'b1, esq_pkg::OFS_CTRL, 32'h0000_0010);
    rd_chk(esq_pkg::OFS_INCL, 32'h0000_0000, "inclusion");
    sw = 20'($random(seed));
    bus(1'b1, esq_pkg::OFS_SW, 32'(sw));
    rd_chk(esq_pkg::OFS_SW, 32'(sw), "switch");
    chk(32'(relay), 32'(sw), "switch relays");
    mux <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1'b1, esq_pkg::OFS_SW, 32'(~sw));
    rd_chk(esq_pkg::OFS_SW, 32'(sw), "switch on non-mux");
    mux <= 1'b1;
    repeat (4) @(posedge clock);
    bus(1'b1, esq_pkg::OFS_FUNC, 32'h0000_0503);
    rd_chk(esq_pkg::OFS_INCL, 32'h0000_0008, "inclusion");
    rd_chk(esq_pkg::OFS_SW, 32'(sw & 20'hf_fff7), "switch");
    bus(1'b1, esq_pkg::OFS_JOIN, 32'h0000_0001);
    @(negedge clock);
    chk(32'(join_en), 32'h000f_fff7, "bank join");
    bus(1'b1, esq_pkg::OFS_JOIN, 32'h0000_0000);
    @(negedge clock);
    chk(32'(join_en), 32'h0000_0000, "bank join");
    stop_test();
  end
endmodule // tb
